/* File: common/dual_timer_pkg.sv */
// Constants, register map and types shared by the dual timer/event counter
package dual_timer_pkg;

  // Channel count and counter geometry
  localparam int NUM_CH = 2;
  localparam int CNT_W = 16;
  localparam int BYTE_W = 8;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;

  // Register indices; byte address is the index times four
  localparam int IDX_LSB = 2;
  localparam int IDX_W = ADDR_W - IDX_LSB;
  localparam logic [IDX_W-1:0] IDX_IRQ_CTRL = 6'h0b;
  localparam logic [IDX_W-1:0] IDX_HIGH [NUM_CH] = '{6'h0c, 6'h0f};
  localparam logic [IDX_W-1:0] IDX_LOW [NUM_CH] = '{6'h0d, 6'h10};
  localparam logic [IDX_W-1:0] IDX_CTRL [NUM_CH] = '{6'h0e, 6'h11};

  // Control register field positions
  localparam int CTRL_EDGE_BIT = 3;
  localparam int CTRL_RUN_BIT = 4;
  localparam int CTRL_MODE_LSB = 6;

  // Interrupt control register field positions
  localparam int IRQ_EN_LSB = 1;
  localparam int IRQ_FLAG_LSB = 5;

  // System clock division for the instruction clock
  localparam int SYS_DIV = 4;
  localparam int DIV_W = 2;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SYS_DIV - 1);

  // Operating modes, encoded as in the control register
  typedef enum logic [1:0] {
    MODE_UNUSED = 2'b00,
    MODE_EVENT  = 2'b01,
    MODE_TIMER  = 2'b10,
    MODE_PULSE  = 2'b11
  } mode_t;

  // Software-visible control fields of one counter
  typedef struct packed {
    mode_t mode;
    logic  run;
    logic  edge_sel;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = '{mode: MODE_UNUSED, run: 1'b0, edge_sel: 1'b1};

  // Pulse-width measurement progress
  typedef enum logic {
    PW_WAIT,
    PW_MEASURE
  } pw_state_t;

endpackage

/* File: logic/dual_timer_event_counter.sv */
// Two 16-bit timer/event counters with an APB register slave
//
// Operation
// - Two 16-bit up-counters, pin, sys/4 or RTC clock
// - Internal clock chosen by build option
// - Low-byte write only fills the buffer
// - High-byte write loads preload with buffer
// - High read returns high, captures low byte
// - Control bits 0-2 and 5 read zero
// - Control bit 3 selects falling edge
// - Control bit 4 enables counting
// - Control bits 7:6 select the mode
// - Event counts pin edges, timer counts ticks
// - Overflow reloads preload and sets flag
// - Pulse mode counts until pin returns, stops
// - One measurement until enable set again
// - Pulse measurement starts on an edge
// - Pulse mode overflow behaves like others
// - Event and timer enable cleared only by software
// - Overflow is a wake-up source
// - Interrupt enable zero masks the overflow
// - Preload write loads counter when stopped
// - Counting blocked during a counter read
`timescale 1ns/1ps

module dual_timer_event_counter
  import dual_timer_pkg::*;
#(
  parameter logic [dual_timer_pkg::NUM_CH-1:0] USE_RTC_OPTION = '0,
  parameter logic                              OSC_INT_RC_RTC = 1'b0
) (
  // Clock and reset
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  // APB slave
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [dual_timer_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [dual_timer_pkg::DATA_W-1:0]   pwdata,
  output logic      [dual_timer_pkg::DATA_W-1:0]   prdata,
  output logic                                     pready,
  output logic                                     pslverr,
  // External event pins and low-frequency oscillator
  input  wire logic [dual_timer_pkg::NUM_CH-1:0]   event_pin,
  input  wire logic                                low_freq_osc_clock,
  // Requests toward the interrupt and halt logic
  output logic      [dual_timer_pkg::NUM_CH-1:0]   irq_request,
  output logic                                     wake_pulse
);
  import dual_timer_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // APB decode and handshake

  logic              access;
  logic              done;
  logic              wr_done;
  logic              rd_sample;
  logic [IDX_W-1:0]  idx;
  logic              aligned;
  logic              hit_irq;
  logic              mapped;
  logic [DATA_W-1:0] rd_word;
  logic              next_pready;
  logic [DATA_W-1:0] next_prdata;
  logic              next_pslverr;

  logic [NUM_CH-1:0] hit_high;
  logic [NUM_CH-1:0] hit_low;
  logic [NUM_CH-1:0] hit_ctrl;
  logic [DATA_W-1:0] chan_rd [NUM_CH];

  logic [NUM_CH-1:0] irq_en;
  logic [NUM_CH-1:0] ovf_flag;
  logic [NUM_CH-1:0] ovf;

  // One wait state: read data is sampled in the first access cycle, write data in the ready cycle
  always_comb begin
    access = psel & penable;
    done = access & pready;
    wr_done = done & pwrite;
    rd_sample = access & ~pready & ~pwrite;
    idx = paddr[ADDR_W-1:IDX_LSB];
    aligned = (paddr[IDX_LSB-1:0] == '0);
    hit_irq = aligned & (idx == IDX_IRQ_CTRL);
    mapped = hit_irq | (|hit_high) | (|hit_low) | (|hit_ctrl);
    rd_word = '0;
    if (hit_irq) begin
      rd_word[IRQ_EN_LSB +: NUM_CH] = irq_en;
      rd_word[IRQ_FLAG_LSB +: NUM_CH] = ovf_flag;
    end
    for (int c = 0; c < NUM_CH; c++) begin
      rd_word = rd_word | chan_rd[c];
    end
    next_pready = access & ~pready;
    next_prdata = prdata;
    next_pslverr = 1'b0;              // Error only stands with its ready cycle
    if (access & ~pready) begin
      next_prdata = pwrite ? '0 : rd_word;
      next_pslverr = ~mapped;         // Unmapped or misaligned address
    end
  end

  // Bus answer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Internal time bases

  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] next_div_cnt;
  logic             rtc_q1;
  logic             rtc_q2;
  logic             sys_tick;
  logic             rtc_tick;

  // Instruction clock tick and low-frequency oscillator rising edge
  always_comb begin
    next_div_cnt = div_cnt + DIV_W'(1);
    sys_tick = (div_cnt == DIV_LAST);
    rtc_tick = rtc_q1 & ~rtc_q2;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= '0;
      rtc_q1 <= 1'b0;
      rtc_q2 <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      rtc_q1 <= low_freq_osc_clock;
      rtc_q2 <= rtc_q1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Counter channels

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    logic [CNT_W-1:0]  count;
    logic [CNT_W-1:0]  preload;
    logic [BYTE_W-1:0] low_buf;
    ctrl_t             ctrl;
    pw_state_t         pw;
    logic              pin_q;
    logic [CNT_W-1:0]  next_count;
    logic [CNT_W-1:0]  next_preload;
    logic [BYTE_W-1:0] next_low_buf;
    ctrl_t             next_ctrl;
    pw_state_t         next_pw;
    logic              rise;
    logic              fall;
    logic              act_edge;
    logic              ret_edge;
    logic              itick;
    logic              inc;
    logic              use_rtc;

    // RTC source only exists with the internal RC plus RTC oscillator
    assign use_rtc = USE_RTC_OPTION[ch] & OSC_INT_RC_RTC;

    assign hit_high[ch] = aligned & (idx == IDX_HIGH[ch]);
    assign hit_low[ch] = aligned & (idx == IDX_LOW[ch]);
    assign hit_ctrl[ch] = aligned & (idx == IDX_CTRL[ch]);

    // Read view; unused control bits stay zero
    always_comb begin
      chan_rd[ch] = '0;
      if (hit_high[ch]) begin
        chan_rd[ch][BYTE_W-1:0] = count[CNT_W-1:BYTE_W];
      end
      if (hit_low[ch]) begin
        chan_rd[ch][BYTE_W-1:0] = low_buf;
      end
      if (hit_ctrl[ch]) begin
        chan_rd[ch][CTRL_EDGE_BIT] = ctrl.edge_sel;
        chan_rd[ch][CTRL_RUN_BIT] = ctrl.run;
        chan_rd[ch][CTRL_MODE_LSB +: 2] = ctrl.mode;
      end
    end

    // Counting, pulse measurement and register side effects
    always_comb begin
      next_count = count;
      next_preload = preload;
      next_low_buf = low_buf;
      next_ctrl = ctrl;
      next_pw = pw;
      ovf[ch] = 1'b0;
      rise = event_pin[ch] & ~pin_q;
      fall = ~event_pin[ch] & pin_q;
      act_edge = ctrl.edge_sel ? fall : rise;
      ret_edge = ctrl.edge_sel ? rise : fall;
      itick = use_rtc ? rtc_tick : sys_tick;
      unique case (ctrl.mode)
        MODE_EVENT:  inc = act_edge;
        MODE_TIMER:  inc = itick;
        MODE_PULSE:  inc = (pw == PW_MEASURE) & itick & ~ret_edge;
        MODE_UNUSED: inc = 1'b0;
      endcase
      // A read of the high byte blocks this tick so capture is coherent
      inc = inc & ctrl.run & ~(rd_sample & hit_high[ch]);
      if (inc) begin
        if (count == CNT_MAX) begin
          next_count = preload;
          ovf[ch] = 1'b1;
        end else begin
          next_count = count + CNT_W'(1);
        end
      end
      // Only pulse mode lets hardware clear the run bit
      if (!(ctrl.run && ctrl.mode == MODE_PULSE)) begin
        next_pw = PW_WAIT;
      end else begin
        unique case (pw)
          PW_WAIT: begin
            if (act_edge) begin
              next_pw = PW_MEASURE;
            end
          end
          PW_MEASURE: begin
            if (ret_edge) begin
              next_pw = PW_WAIT;
              next_ctrl.run = 1'b0;
            end
          end
        endcase
      end
      if (rd_sample && hit_high[ch]) begin
        next_low_buf = count[BYTE_W-1:0];
      end
      if (wr_done && hit_low[ch]) begin
        next_low_buf = pwdata[BYTE_W-1:0];
      end
      if (wr_done && hit_high[ch]) begin
        next_preload = {pwdata[BYTE_W-1:0], low_buf};
        if (!ctrl.run) begin
          next_count = {pwdata[BYTE_W-1:0], low_buf};
        end
      end
      // Software write wins over the automatic run clear
      if (wr_done && hit_ctrl[ch]) begin
        next_ctrl.edge_sel = pwdata[CTRL_EDGE_BIT];
        next_ctrl.run = pwdata[CTRL_RUN_BIT];
        next_ctrl.mode = mode_t'(pwdata[CTRL_MODE_LSB +: 2]);
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        count <= CNT_RESET;
        preload <= CNT_RESET;
        low_buf <= '0;
        ctrl <= CTRL_RESET;
        pw <= PW_WAIT;
        pin_q <= 1'b0;
      end else begin
        count <= next_count;
        preload <= next_preload;
        low_buf <= next_low_buf;
        ctrl <= next_ctrl;
        pw <= next_pw;
        pin_q <= event_pin[ch];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Overflow flags, interrupt enables and wake-up

  logic [NUM_CH-1:0] next_irq_en;
  logic [NUM_CH-1:0] next_ovf_flag;
  logic [NUM_CH-1:0] next_irq_request;
  logic              next_wake_pulse;

  // Flag set by overflow beats a clearing write in the same cycle
  always_comb begin
    next_irq_en = irq_en;
    next_ovf_flag = ovf_flag;
    if (wr_done && hit_irq) begin
      next_irq_en = pwdata[IRQ_EN_LSB +: NUM_CH];
      next_ovf_flag = pwdata[IRQ_FLAG_LSB +: NUM_CH];
    end
    next_ovf_flag = next_ovf_flag | ovf;
    next_irq_request = next_ovf_flag & next_irq_en;
    next_wake_pulse = |ovf;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en <= '0;
      ovf_flag <= '0;
      irq_request <= '0;
      wake_pulse <= 1'b0;
    end else begin
      irq_en <= next_irq_en;
      ovf_flag <= next_ovf_flag;
      irq_request <= next_irq_request;
      wake_pulse <= next_wake_pulse;
    end
  end

endmodule

/* File: testbench/dual_timer_assertions.sv */
// Port-level checker for the dual timer, bound to the top module
`timescale 1ns/1ps
module dual_timer_checker
  import dual_timer_pkg::*;
(
  // Clock and reset
  input wire logic                      pclk,
  input wire logic                      presetn,
  // APB slave
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [ADDR_W-1:0]         paddr,
  input wire logic [DATA_W-1:0]         pwdata,
  input wire logic [DATA_W-1:0]         prdata,
  input wire logic                      pready,
  input wire logic                      pslverr,
  // Pins and requests
  input wire logic [NUM_CH-1:0]         event_pin,
  input wire logic                      low_freq_osc_clock,
  input wire logic [NUM_CH-1:0]         irq_request,
  input wire logic                      wake_pulse
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // One wait state, then a single ready cycle
  a_ready_timing: assert property (psel && penable && !pready |=> pready)
    else $error("ready not one cycle after access");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("ready without access");
  a_err_qualified: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  // Places above index 0x11 are refused with zero data
  a_unmapped_err: assert property (psel && penable && !pready && paddr[7:2] > 6'h11
    |=> pslverr && prdata == '0) else $error("unmapped access not refused");
  a_ctrl_zero_bits: assert property (
    pready && !pwrite && (paddr[7:2] == IDX_CTRL[0] || paddr[7:2] == IDX_CTRL[1])
    |-> prdata[2:0] == 3'h0 && !prdata[5]) else $error("unused control bits set");
  // Request zero rises only from an overflow or a software write
  a_irq_cause: assert property (
    $rose(irq_request[0]) |-> wake_pulse || $past(wake_pulse) || $past(pwrite && pready))
    else $error("request without overflow");
endmodule

bind dual_timer_event_counter dual_timer_checker chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .event_pin(event_pin),
  .low_freq_osc_clock(low_freq_osc_clock), .irq_request(irq_request),
  .wake_pulse(wake_pulse));

/* File: testbench/event_source.sv */
// Model of the external event pins and the slow oscillator
`timescale 1ns/1ps
module event_source (
  // Clock
  input  wire logic       pclk,
  // Driven levels
  output logic      [1:0] pin,
  output logic            osc
);
  logic [2:0] div;
  initial begin
    pin = 2'b00;
    osc = 1'b0;
    div = 3'h0;
  end
  // Slow oscillator, one toggle per eight cycles
  always @(posedge pclk) begin
    div <= div + 3'h1;
    if (div == 3'h7) osc <= ~osc;
  end
  // Levels change just after an edge so the sampling is unambiguous
  task automatic drive(input int ch, input logic v);
    @(posedge pclk);
    pin[ch] <= v;
  endtask
  // One high pulse of n cycles
  task automatic pulse(input int ch, input int n);
    drive(ch, 1'b1);
    repeat (n) @(posedge pclk);
    pin[ch] <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
endmodule

/* File: testbench/dual_timer_event_counter_bench.sv */
// Register-level bench for the dual timer/event counter
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module dual_timer_event_counter_bench;
  import dual_timer_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, wake_pulse;
  logic [7:0]  paddr = '0, q, v;
  logic [31:0] pwdata = '0, prdata;
  logic [1:0]  pin, irq_request;
  logic        osc, e;
  int mismatches = 0, num_checks = 0, cycles = 0, wakes = 0;
  ////////////////////////////////////////////////////////////////////////////
  always #4 pclk = ~pclk;
  event_source src (.pclk(pclk), .pin(pin), .osc(osc));
  dual_timer_event_counter dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .event_pin(pin), .low_freq_osc_clock(osc),
    .irq_request(irq_request), .wake_pulse(wake_pulse));
  task automatic conclude();
    if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard, far above the run length; also tallies wake-up pulses
  always @(posedge pclk) begin
    cycles++;
    if (wake_pulse === 1'b1) wakes++;
    if (cycles == 5000) begin
      mismatches++;
      conclude();
    end
  end
  // One APB transfer; held until ready is sampled
  task automatic xfer(input logic w, input logic [5:0] i, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= {i, 2'b00}; pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata[7:0];
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [5:0] i, input logic [7:0] x);
    xfer(0, i, 8'h00);
    `CHK(q, x)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    rd(6'h0e, 8'h08); rd(6'h11, 8'h08); rd(6'h0b, 8'h00);
    xfer(1, 6'h0e, 8'hff); rd(6'h0e, 8'hd8);
    xfer(1, 6'h0e, 8'h08);
    // Preload path while stopped
    xfer(1, 6'h0d, 8'h34); rd(6'h0c, 8'h00);
    xfer(1, 6'h0d, 8'hfe); xfer(1, 6'h0c, 8'hff);
    rd(6'h0c, 8'hff); rd(6'h0d, 8'hfe);
    // Event count on rising edges through an overflow
    xfer(1, 6'h0b, 8'h02); xfer(1, 6'h0e, 8'h50);
    src.pulse(0, 3); src.pulse(0, 3);
    `CHK(irq_request, 2'b01)
    `CHK(wakes, 1)
    rd(6'h0b, 8'h22); rd(6'h0c, 8'hff); rd(6'h0d, 8'hfe);
    rd(6'h0e, 8'h50);
    // Masked overflow still flags but does not request
    xfer(1, 6'h0b, 8'h00);
    src.pulse(0, 3); src.pulse(0, 3);
    `CHK(irq_request, 2'b00)
    `CHK(wakes, 2)
    rd(6'h0b, 8'h20);
    xfer(1, 6'h0b, 8'h00);
    // Timer on counter one, sixteen ticks to overflow
    xfer(1, 6'h10, 8'hf0); xfer(1, 6'h0f, 8'hff); xfer(1, 6'h11, 8'h90);
    repeat (100) @(posedge pclk);
    rd(6'h0b, 8'h40); rd(6'h0f, 8'hff);
    `CHK(wakes, 3)
    `CHK(irq_request, 2'b00)
    xfer(1, 6'h11, 8'h08); rd(6'h11, 8'h08);
    // Pulse width: level alone must not start, edge does
    xfer(1, 6'h0e, 8'h08); xfer(1, 6'h0d, 8'h00); xfer(1, 6'h0c, 8'h00);
    src.drive(0, 1'b1); xfer(1, 6'h0e, 8'hd0);
    repeat (20) @(posedge pclk);
    rd(6'h0c, 8'h00); rd(6'h0d, 8'h00);
    src.drive(0, 1'b0); repeat (8) @(posedge pclk);
    src.pulse(0, 40);
    rd(6'h0e, 8'hc0); rd(6'h0c, 8'h00);
    v = q;
    xfer(0, 6'h0d, 8'h00); v = q;
    `CHK(v >= 8'h08 && v <= 8'h0b, 1'b1)
    src.pulse(0, 40);
    rd(6'h0c, 8'h00); rd(6'h0d, v);
    `CHK(wakes, 3)
    // Unmapped place is refused
    xfer(0, 6'h3f, 8'h00);
    `CHK({e, q}, 9'h100)
    conclude();
  end
endmodule
